// >>> sleep_ctrl_pkg.sv
// shared constants and types for the sleep-mode clock controller
package sleep_ctrl_pkg;
    // ==========================================
    // sleep mode field encodings
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_NOISE = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    // ==========================================
    // start-up delay in cycles per clock source fuse setting
    localparam int FUSE_W = 4;
    localparam int DELAY_W = 16;
    localparam logic [DELAY_W-1:0] DELAY_BASE = 16'h0010;
    localparam logic [DELAY_W-1:0] DELAY_MIN = 16'h0001;
    // ==========================================
    // controller states
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WAKE = 2'b10
    } sleep_state_t;
endpackage

// >>> wake_delay.sv
// start-up delay counter run after wake from an oscillator-stopped sleep
`timescale 1ns/1ps
module wake_delay
    import sleep_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic start,
    input wire logic [sleep_ctrl_pkg::FUSE_W-1:0] fuses,
    // status
    output logic done
);
    // length grows with the fuse code, never below one cycle
    function automatic logic [DELAY_W-1:0] delay_of(
        input logic [FUSE_W-1:0] f);
        logic [DELAY_W-1:0] d;
        d = DELAY_MIN + (DELAY_BASE * {{(DELAY_W-FUSE_W){1'b0}}, f});
        return d;
    endfunction

    logic [DELAY_W-1:0] cnt_reg;
    logic busy_reg;

    // load on start, count down, flag when spent
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
        end else if (start) begin
            cnt_reg <= delay_of(fuses);
            busy_reg <= 1'b1;
        end else if (busy_reg && cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end else begin
            busy_reg <= 1'b0;
        end
    end

    assign done = busy_reg && (cnt_reg == '0);
endmodule

// >>> sleep_ctrl.sv
// sleep-mode clock gating controller with wake-source qualification
//
// Contract
// - mode 000 plus sleep gates core and program-memory clocks only.
// - idle wakes on external and internal interrupts.
// - idle or noise-reduction with converter enabled starts a conversion.
// - mode 001 gates I/O, core and program-memory clocks.
// - noise-reduction wakes only on its listed sources.
// - mode 010 stops oscillator and all generated clocks.
// - power-down wakes only on resets, address match, external interrupts.
// - wake from power-down waits a fuse-selected start-up delay.
// - mode 011 acts like power-down.
// - comparator disable removes comparator as idle wake source.
`timescale 1ns/1ps
module sleep_ctrl
    import sleep_ctrl_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // processor core request
    input wire logic sleep_exec,
    input wire logic sleep_enable,
    input wire logic [2:0] sleep_mode_select,
    // configuration
    input wire logic converter_enable,
    input wire logic comparator_disable,
    input wire logic [sleep_ctrl_pkg::FUSE_W-1:0] clock_source_fuses,
    // wake sources, internal logic on this clock
    input wire logic timer_irq,
    input wire logic serial_irq,
    input wire logic comparator_irq,
    input wire logic conversion_done_irq,
    input wire logic timer2_irq,
    input wire logic store_ready_irq,
    input wire logic addr_match_irq,
    input wire logic reset_req,
    // wake sources from pins
    input wire logic [3:0] upper_external_irq_inputs,
    input wire logic [3:0] lower_external_irq_inputs,
    // clock gates, high means the clock runs
    output logic core_clk_en,
    output logic flash_clk_en,
    output logic io_clk_en,
    output logic osc_en,
    // converter start pulse and status
    output logic conversion_start,
    output logic sleeping
);
    // ==========================================
    // reset release
    logic rst_s1_reg, rst_n_reg;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    // ==========================================
    // pin synchronisers; first stage read only by second
    logic [7:0] ext_s1_reg, ext_s2_reg;
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ext_s1_reg <= 8'h00;
            ext_s2_reg <= 8'h00;
        end else begin
            ext_s1_reg <= {upper_external_irq_inputs,
                lower_external_irq_inputs};
            ext_s2_reg <= ext_s1_reg;
        end
    end

    // ==========================================
    // wake qualification per mode
    // a level sampled once counts when it reaches the second sync stage
    wire ext_any = |ext_s2_reg;
    wire idle_wake = ext_any || timer_irq || serial_irq || addr_match_irq
        || conversion_done_irq || timer2_irq || store_ready_irq
        || reset_req || (comparator_irq && !comparator_disable);
    wire noise_wake = conversion_done_irq || reset_req || addr_match_irq
        || timer2_irq || store_ready_irq || ext_any;
    wire pdown_wake = reset_req || addr_match_irq || ext_any;

    logic [2:0] mode_reg, mode_next;
    sleep_state_t state_reg, state_next;
    wire osc_off_mode = (mode_reg == MODE_PDOWN) ||
        (mode_reg == MODE_PSAVE);
    wire legal_mode = (sleep_mode_select <= MODE_PSAVE);
    wire enter = sleep_exec && sleep_enable && legal_mode;
    wire wake_now = (mode_reg == MODE_IDLE) ? idle_wake :
        (mode_reg == MODE_NOISE) ? noise_wake : pdown_wake;
    wire delay_start = (state_reg == ST_SLEEP) && wake_now && osc_off_mode;
    logic delay_done;

    // start-up delay after the oscillator was stopped
    wake_delay u_delay (
        .clk(core_clk),
        .rst_n(rst_n_reg),
        .start(delay_start),
        .fuses(clock_source_fuses),
        .done(delay_done)
    );

    // ==========================================
    // state transitions
    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        case (state_reg)
            ST_RUN: begin
                if (enter) begin
                    state_next = ST_SLEEP;
                    mode_next = sleep_mode_select;
                end
            end
            ST_SLEEP: begin
                if (wake_now) begin
                    state_next = osc_off_mode ? ST_WAKE : ST_RUN;
                end
            end
            ST_WAKE: begin
                if (delay_done) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= ST_RUN;
            mode_reg <= MODE_IDLE;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
        end
    end

    // ==========================================
    // gate outputs registered to avoid glitches on clock enables
    wire asleep_next = (state_next != ST_RUN);
    wire gate_core = asleep_next;
    wire gate_io = asleep_next && (mode_next != MODE_IDLE);
    // oscillator back on in the start-up delay, else it never settles
    wire stop_osc = (state_next == ST_SLEEP) && ((mode_next == MODE_PDOWN) ||
        (mode_next == MODE_PSAVE));
    wire conv_go = (state_reg == ST_RUN) && enter && converter_enable &&
        ((sleep_mode_select == MODE_IDLE) ||
        (sleep_mode_select == MODE_NOISE));

    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            core_clk_en <= 1'b1;
            flash_clk_en <= 1'b1;
            io_clk_en <= 1'b1;
            osc_en <= 1'b1;
            conversion_start <= 1'b0;
            sleeping <= 1'b0;
        end else begin
            core_clk_en <= !gate_core;
            flash_clk_en <= !gate_core;
            io_clk_en <= !gate_io;
            osc_en <= !stop_osc;
            conversion_start <= conv_go;
            sleeping <= asleep_next;
        end
    end

    // ==========================================
    // checks
    a_idle_gating: assert property (
        @(posedge core_clk) disable iff (!rst_n_reg)
        (state_reg == ST_RUN && enter && sleep_mode_select == MODE_IDLE)
        |=> (!core_clk_en && io_clk_en && osc_en))
        else $error("idle gating wrong");
    // enables come back at the very edge that sees the wake source
    a_idle_wake: assert property (
        @(posedge core_clk) disable iff (!rst_n_reg)
        (state_reg == ST_SLEEP && mode_reg == MODE_IDLE && timer_irq)
        |=> core_clk_en)
        else $error("idle no wake");
    a_conv_start: assert property (
        @(posedge core_clk) disable iff (!rst_n_reg)
        (state_reg == ST_RUN && enter && converter_enable &&
        sleep_mode_select == MODE_NOISE) |=> conversion_start)
        else $error("no conversion start");
    a_idle_conv: assert property (
        @(posedge core_clk) disable iff (!rst_n_reg)
        (state_reg == ST_RUN && enter && converter_enable &&
        sleep_mode_select == MODE_IDLE) |=> conversion_start)
        else $error("no idle conversion start");
    a_noise_gating: assert property (
        @(posedge core_clk) disable iff (!rst_n_reg)
        (state_reg == ST_RUN && enter && sleep_mode_select == MODE_NOISE)
        |=> (!io_clk_en && osc_en))
        else $error("noise gating wrong");
    a_noise_block: assert property (
        @(posedge core_clk) disable iff (!rst_n_reg)
        (state_reg == ST_SLEEP && mode_reg == MODE_NOISE && !noise_wake)
        |=> state_reg == ST_SLEEP)
        else $error("noise false wake");
    a_pdown_osc: assert property (
        @(posedge core_clk) disable iff (!rst_n_reg)
        (state_reg == ST_SLEEP && osc_off_mode) |-> !osc_en)
        else $error("oscillator running");
    a_pdown_block: assert property (
        @(posedge core_clk) disable iff (!rst_n_reg)
        (state_reg == ST_SLEEP && osc_off_mode && !pdown_wake)
        |=> state_reg == ST_SLEEP)
        else $error("power-down false wake");
    a_wake_delay: assert property (
        @(posedge core_clk) disable iff (!rst_n_reg)
        delay_start |=> !core_clk_en [*2])
        else $error("start-up delay skipped");
    // core stays gated while the restarted oscillator settles
    a_wake_osc: assert property (
        @(posedge core_clk) disable iff (!rst_n_reg)
        (state_reg == ST_WAKE) |-> (osc_en && !core_clk_en))
        else $error("clock not restarting");
    a_cmp_off: assert property (
        @(posedge core_clk) disable iff (!rst_n_reg)
        (state_reg == ST_SLEEP && mode_reg == MODE_IDLE &&
        !idle_wake && comparator_irq) |=> state_reg == ST_SLEEP)
        else $error("comparator woke");
    a_nop_sleep: assert property (
        @(posedge core_clk) disable iff (!rst_n_reg)
        (state_reg == ST_RUN && sleep_exec && !sleep_enable)
        |=> (core_clk_en && !sleeping))
        else $error("sleep not nop");
endmodule

// >>> sleep_core_model.sv
// processor core model that issues sleep instructions to the controller
`timescale 1ns/1ps
module sleep_core_model (
    // clock
    input wire logic core_clk,
    // controller status
    input wire logic core_clk_en,
    // sleep request
    output logic sleep_exec,
    output logic sleep_enable,
    output logic [2:0] sleep_mode_select
);
    logic en_prev = 1'b1;
    initial begin
        sleep_exec = 1'b0;
        sleep_enable = 1'b0;
        sleep_mode_select = 3'h0;
    end
    // ==========================================
    // sleep request: enable one cycle ahead, instruction for one cycle
    task automatic do_sleep(input logic [2:0] mode, input logic se);
        @(negedge core_clk);
        sleep_enable = se;
        sleep_mode_select = mode;
        @(negedge core_clk);
        sleep_exec = 1'b1;
        @(negedge core_clk);
        sleep_exec = 1'b0;
        @(negedge core_clk);
    endtask
    // clear enable once the core clock is back, so a stray sleep is a no-op
    always @(negedge core_clk) begin
        if (core_clk_en && !en_prev) sleep_enable = 1'b0;
        en_prev = core_clk_en;
    end
endmodule

// >>> sleep_ctrl_tb.sv
// self-checking bench for the sleep-mode clock controller
`timescale 1ns/1ps
module sleep_ctrl_tb;
    import sleep_ctrl_pkg::*;
    logic core_clk, reset_n = 1'b0, converter_enable = 1'b0;
    logic comparator_disable = 1'b0, sleep_exec, sleep_enable;
    logic core_clk_en, flash_clk_en, io_clk_en, osc_en;
    logic conversion_start, sleeping;
    logic [2:0] sleep_mode_select;
    logic [FUSE_W-1:0] clock_source_fuses = '0;
    logic [7:0] irq_v = 8'h00;
    logic [3:0] upper_pins = 4'h0, lower_pins = 4'h0;
    int mismatches = 0, checks_done = 0, conv_cnt = 0, cnt, exp_lat, c0;
    // core clock back one edge after a source is seen, pins add two
    localparam int WAKE_LAT = 1;
    localparam int SYNC_LAT = 2;
    int bad[4] = '{2, 1, 4, 0};
    int good[4] = '{0, 3, 6, 7};
    // ==========================================
    // clock, 100 ns period
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // conversion pulses are counted so a one-cycle pulse is never missed
    always @(negedge core_clk) if (conversion_start === 1'b1) conv_cnt++;
    sleep_core_model u_core (.core_clk(core_clk), .core_clk_en(core_clk_en),
        .sleep_exec(sleep_exec), .sleep_enable(sleep_enable),
        .sleep_mode_select(sleep_mode_select));
    sleep_ctrl u_dut (.core_clk(core_clk), .reset_n(reset_n),
        .sleep_exec(sleep_exec), .sleep_enable(sleep_enable),
        .sleep_mode_select(sleep_mode_select),
        .converter_enable(converter_enable),
        .comparator_disable(comparator_disable),
        .clock_source_fuses(clock_source_fuses), .timer_irq(irq_v[0]),
        .serial_irq(irq_v[1]), .comparator_irq(irq_v[2]),
        .conversion_done_irq(irq_v[3]), .timer2_irq(irq_v[4]),
        .store_ready_irq(irq_v[5]), .addr_match_irq(irq_v[6]),
        .reset_req(irq_v[7]), .upper_external_irq_inputs(upper_pins),
        .lower_external_irq_inputs(lower_pins), .core_clk_en(core_clk_en),
        .flash_clk_en(flash_clk_en), .io_clk_en(io_clk_en), .osc_en(osc_en),
        .conversion_start(conversion_start), .sleeping(sleeping));
    // ==========================================
    // comparison and verdict
    task automatic check(input string what, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // wake source held as a level until the core clock returns
    task automatic wake(input int idx, input logic [3:0] lo, up);
        @(negedge core_clk);
        irq_v = 8'h01 << idx;
        lower_pins = lo;
        upper_pins = up;
        cnt = 0;
        while (core_clk_en !== 1'b1 && cnt < 100) begin
            @(negedge core_clk);
            cnt++;
        end
        // a wake that never comes is a failure, not a silent pass
        if (cnt >= 100) begin
            mismatches++;
            stop_test();
        end
        irq_v = 8'h00;
        lower_pins = 4'h0;
        upper_pins = 4'h0;
    endtask
    // ==========================================
    // hang guard; the tests need about 120 cycles
    initial begin
        repeat (2000) @(posedge core_clk);
        mismatches++;
        stop_test();
    end
    // main sequence
    initial begin
        repeat (6) @(negedge core_clk);
        check("reset_gates", {core_clk_en, io_clk_en, osc_en, sleeping}, 4'he);
        check("reset_conv", conversion_start, 1'b0);
        reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        comparator_disable = 1'b1;
        converter_enable = 1'b1;
        for (int m = 0; m < 4; m++) begin
            clock_source_fuses = (m == 2) ? 4'h1 : 4'h0;
            c0 = conv_cnt;
            u_core.do_sleep(m[2:0], 1'b1);
            check("sleep_gates", {core_clk_en, flash_clk_en, io_clk_en, osc_en,
                sleeping}, {2'b00, m == 0, m < 2, 1'b1});
            check("conv_pulses", conv_cnt - c0, m < 2);
            irq_v = 8'h01 << bad[m];
            repeat (8) @(negedge core_clk);
            check("no_wake", {core_clk_en, sleeping}, 2'b01);
            irq_v = 8'h00;
            wake(good[m], 4'h0, 4'h0);
            // oscillator-off modes add the start-up count and its done cycle
            exp_lat = WAKE_LAT + ((m < 2) ? 0 : 1 + DELAY_MIN +
                DELAY_BASE * clock_source_fuses);
            check("wake_cycles", cnt, exp_lat);
            check("woke_gates", {core_clk_en, flash_clk_en, io_clk_en, osc_en,
                sleeping}, 5'h1e);
        end
        u_core.do_sleep(3'h0, 1'b0);
        check("no_op", {core_clk_en, io_clk_en, sleeping}, 3'h6);
        u_core.do_sleep(3'h5, 1'b1);
        check("bad_mode", {core_clk_en, io_clk_en, sleeping}, 3'h6);
        comparator_disable = 1'b0;
        converter_enable = 1'b0;
        c0 = conv_cnt;
        u_core.do_sleep(3'h0, 1'b1);
        check("conv_off", conv_cnt - c0, 0);
        wake(2, 4'h0, 4'h0);
        check("comp_wake", cnt, WAKE_LAT);
        u_core.do_sleep(3'h0, 1'b1);
        wake(8, 4'h1, 4'h0);
        check("pin_wake", cnt, WAKE_LAT + SYNC_LAT);
        u_core.do_sleep(3'h2, 1'b1);
        wake(8, 4'h0, 4'h8);
        check("pin_pdown", cnt, WAKE_LAT + SYNC_LAT + 1 + DELAY_MIN);
        stop_test();
    end
endmodule
